//--- src/tps_pkg.sv
// What this block does
// - Poll listed remotes in order, one each
// - Finished notice queues the next list entry
// - No-data notice polls next entry next hop
// - Advance only on a hop boundary
// - Silent remote repolled until timeout, then move
// - Timeout counted in hops, default ten
// - Lost finished notice waits full timeout
// - After last valid entry wrap to first
// - List holds 8192 entries
// - Write index 0-8191, address 0-65534, zero terminates
// - Single read returns stored unit address
// - View command streams whole list
// - Default list holds addresses 2 through 8193
// - Mode value 1 selects standard polling
package tps_pkg;
  // ****************************************
  // Sizes and constants
  // ****************************************
  localparam int unsigned IDX_W = 13;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned LIST_DEPTH = 8192;
  localparam logic [IDX_W-1:0] LAST_IDX = 13'h1fff;
  localparam logic [ADDR_W-1:0] ADDR_TERM = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_INVALID = 16'hffff;
  localparam logic [ADDR_W-1:0] DEFAULT_BASE_ADDR = 16'h0002;
  localparam logic [ADDR_W-1:0] MASTER_UNIT_ADDR = 16'h0001;
  localparam logic [7:0] MODE_STANDARD = 8'h01;
  localparam logic [7:0] TIMEOUT_DEFAULT = 8'h0a;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    TPS_OP_WRITE,
    TPS_OP_READ,
    TPS_OP_VIEW,
    TPS_OP_NONE
  } tps_op_t;

  typedef struct packed {
    logic valid;
    tps_op_t op;
    logic [IDX_W-1:0] index;
    logic [ADDR_W-1:0] unit_addr;
  } tps_cmd_t;

  typedef struct packed {
    logic valid;
    logic [IDX_W-1:0] index;
    logic [ADDR_W-1:0] unit_addr;
  } tps_entry_t;
endpackage : tps_pkg

//--- src/tps_scheduler.sv
`timescale 1ns/1ps
module tps_scheduler
  import tps_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Configuration
  input wire logic [7:0] channel_request_mode_sel,
  input wire logic [7:0] hop_allocation_timeout,
  // Hop pacing and remote notices
  input wire logic hop_tick,
  input wire logic rem_done,
  input wire logic rem_no_data,
  // Command port
  input wire tps_cmd_t cmd,
  // Poll grant
  output tps_entry_t poll,
  // Command answers
  output tps_entry_t rd_resp,
  output tps_entry_t view_resp,
  output logic cmd_err,
  output logic list_ready
);
  // ****************************************
  // Reset synchroniser
  // ****************************************
  logic rst_meta_q, rst_n_q;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ****************************************
  // Remote list storage
  // ****************************************
  logic [ADDR_W-1:0] list_mem [LIST_DEPTH];
  logic [IDX_W-1:0] fill_idx_q;
  logic ready_q;
  logic busy_view_q;
  logic [IDX_W-1:0] view_idx_q;
  logic cmd_ok;

  assign cmd_ok = cmd.valid && ready_q && !busy_view_q;

  // Default fill sweep after reset
  // default address fill
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fill_idx_q <= '0;
      ready_q <= 1'b0;
    end else if (!ready_q) begin
      fill_idx_q <= fill_idx_q + 1'b1;
      if (fill_idx_q == LAST_IDX) begin
        ready_q <= 1'b1;
      end
    end
  end

  // Memory writes: fill sweep, then commands
  // full depth list
  always_ff @(posedge core_clk) begin
    if (!ready_q) begin
      list_mem[fill_idx_q] <= DEFAULT_BASE_ADDR + ADDR_W'(fill_idx_q);
    end else if (cmd_ok && cmd.op == TPS_OP_WRITE && cmd.unit_addr != ADDR_INVALID) begin
      list_mem[cmd.index] <= cmd.unit_addr;
    end
  end

  // ****************************************
  // Command answers
  // ****************************************
  // Single read and error report
  // single entry read
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rd_resp <= '0;
      cmd_err <= 1'b0;
    end else begin
      rd_resp.valid <= cmd_ok && cmd.op == TPS_OP_READ;
      rd_resp.index <= cmd.index;
      rd_resp.unit_addr <= list_mem[cmd.index];
      cmd_err <= cmd_ok && cmd.op == TPS_OP_WRITE && cmd.unit_addr == ADDR_INVALID;
    end
  end

  // List view streams every entry, one per cycle
  // whole list view
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      busy_view_q <= 1'b0;
      view_idx_q <= '0;
      view_resp <= '0;
    end else begin
      view_resp.valid <= busy_view_q;
      view_resp.index <= view_idx_q;
      view_resp.unit_addr <= list_mem[view_idx_q];
      if (busy_view_q) begin
        view_idx_q <= view_idx_q + 1'b1;
        if (view_idx_q == LAST_IDX) begin
          busy_view_q <= 1'b0;
        end
      end else if (cmd_ok && cmd.op == TPS_OP_VIEW) begin
        busy_view_q <= 1'b1;
        view_idx_q <= '0;
      end
    end
  end

  assign list_ready = ready_q;

  // ****************************************
  // Polling scheduler
  // ****************************************
  logic run;
  logic active_q;
  logic adv_q;
  logic [IDX_W-1:0] idx_q;
  logic [7:0] cnt_q;
  logic [7:0] tmo_load;
  logic [IDX_W-1:0] nxt_idx;
  logic last_valid;

  assign run = ready_q && channel_request_mode_sel == MODE_STANDARD;
  assign tmo_load = (hop_allocation_timeout == 8'h00) ? 8'h01 : hop_allocation_timeout;
  assign last_valid = (idx_q == LAST_IDX) || (list_mem[idx_q + 1'b1] == ADDR_TERM);
  assign nxt_idx = last_valid ? '0 : idx_q + 1'b1;

  // Response flag: a notice in the hop cycle itself is kept
  // finished notice
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      adv_q <= 1'b0;
    end else if (active_q && (rem_done || rem_no_data)) begin
      adv_q <= 1'b1; // finished or no-data notice
    end else if (hop_tick) begin
      adv_q <= 1'b0;
    end
  end

  // Hop-paced poll issue
  // hop boundary advance
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      active_q <= 1'b0;
      idx_q <= '0;
      cnt_q <= TIMEOUT_DEFAULT;
      poll <= '0;
    end else begin
      poll.valid <= 1'b0;
      if (!run) begin
        active_q <= 1'b0;
      end else if (hop_tick) begin
        if (!active_q) begin
          if (list_mem[0] != ADDR_TERM) begin
            active_q <= 1'b1;
            idx_q <= '0;
            cnt_q <= tmo_load;
            poll <= '{valid: 1'b1, index: '0, unit_addr: list_mem[0]};
          end
        end else if (adv_q || cnt_q <= 8'h01) begin
          if (list_mem[nxt_idx] == ADDR_TERM) begin
            active_q <= 1'b0;
          end else begin
            idx_q <= nxt_idx;
            cnt_q <= tmo_load; // reload per new entry
            poll <= '{valid: 1'b1, index: nxt_idx, unit_addr: list_mem[nxt_idx]};
          end
        end else begin
          cnt_q <= cnt_q - 8'h01;
          poll <= '{valid: 1'b1, index: idx_q, unit_addr: list_mem[idx_q]};
        end
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  // polls only after a hop tick
  a_poll_on_hop: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    poll.valid |-> $past(hop_tick)) else $error("poll without hop tick");
  a_silent_repoll: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    hop_tick && run && active_q && !adv_q && cnt_q > 8'h01
    |=> poll.valid && poll.index == $past(idx_q)) else $error("silent remote not repolled");
  // notice moves index on next poll
  a_notice_adv: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    hop_tick && run && active_q && adv_q && list_mem[nxt_idx] != ADDR_TERM
    |=> poll.index == $past(nxt_idx)) else $error("notice did not advance");
  a_cnt_reload: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    poll.valid && $changed(idx_q) |-> cnt_q == $past(tmo_load)) else $error("counter not reloaded");
  a_wrap_zero: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    hop_tick && run && active_q && adv_q && last_valid && list_mem[0] != ADDR_TERM
    |=> poll.valid && poll.index == '0) else $error("no wrap to first entry");
  a_mode_gate: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    !run |=> !poll.valid) else $error("poll outside standard mode");
  a_read_answer: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    cmd_ok && cmd.op == TPS_OP_READ |=> rd_resp.valid && rd_resp.index == $past(cmd.index))
    else $error("read not answered");
  a_bad_write: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    cmd_ok && cmd.op == TPS_OP_WRITE && cmd.unit_addr == ADDR_INVALID |=> cmd_err)
    else $error("bad write not flagged");
  a_poll_addr: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    poll.valid |-> poll.unit_addr != ADDR_TERM) else $error("terminator polled");
endmodule : tps_scheduler

//--- bench/tps_remote_model.sv
`timescale 1ns/1ps
module tps_remote_model
  import tps_pkg::*;
(
  // Grant from master
  input wire logic core_clk,
  input wire tps_entry_t poll,
  // Notices to master
  output logic rem_done,
  output logic rem_no_data
);
  int cnt;
  logic [1:0] kind;
  logic [15:0] dest_addr_setting = MASTER_UNIT_ADDR;
  // Quiet until polled
  initial begin
    rem_done = 1'b0;
    rem_no_data = 1'b0;
    cnt = 0;
    kind = 2'h0;
  end
  // Answer each poll after a delay set by the address; 15 and 21 stay silent
  // end of turn
  always @(posedge core_clk) begin
    rem_done <= 1'b0;
    rem_no_data <= 1'b0;
    if (poll.valid === 1'b1) begin
      cnt <= poll.unit_addr[1:0] + 1;
      kind <= (poll.unit_addr == 16'h0007) ? 2'h2 :
        (poll.unit_addr == 16'h000f || poll.unit_addr == 16'h0015) ? 2'h0 : 2'h1;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      rem_done <= (cnt == 1) && (kind == 2'h1) && (dest_addr_setting == MASTER_UNIT_ADDR);
      rem_no_data <= (cnt == 1) && (kind == 2'h2) && (dest_addr_setting == MASTER_UNIT_ADDR);
    end
  end
endmodule : tps_remote_model

//--- bench/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin errors++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module testbench;
  import tps_pkg::*;
  logic core_clk, reset_n, hop_tick, rem_done, rem_no_data, cmd_err, list_ready, er, tick_d;
  logic [7:0] mode, tmo;
  logic [15:0] pa;
  tps_cmd_t cmd;
  tps_entry_t poll, rd_resp, view_resp, r;
  int errors = 0, compares = 0, seed = 32'h81adf80a, n, vcnt = 0;
  logic [15:0] exp_q[$];
  logic [12:0] exi_q[$];
  logic [12:0] pi;
  logic [15:0] lst [0:8191];
  logic [15:0] wr [0:5] = '{16'h3, 16'h7, 16'ha, 16'hf, 16'h15, 16'h0};

  tps_scheduler dut (.core_clk(core_clk), .reset_n(reset_n),
    .channel_request_mode_sel(mode), .hop_allocation_timeout(tmo), .hop_tick(hop_tick),
    .rem_done(rem_done), .rem_no_data(rem_no_data), .cmd(cmd), .poll(poll),
    .rd_resp(rd_resp), .view_resp(view_resp), .cmd_err(cmd_err), .list_ready(list_ready));
  tps_remote_model remote (.core_clk(core_clk), .poll(poll), .rem_done(rem_done),
    .rem_no_data(rem_no_data));

  // Clock and watchdog
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    #4_000_000;
    errors++;
    tally_and_finish();
  end

  // Poll and view monitors
  always @(posedge core_clk) begin
    tick_d <= hop_tick;
    if (poll.valid === 1'b1) begin
      pa = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
      pi = (exi_q.size() > 0) ? exi_q.pop_front() : 'x;
      `CHK("poll addr", pa, poll.unit_addr)
      `CHK("poll idx", pi, poll.index)
      `CHK("poll on hop", 1'b1, tick_d)
    end
    if (view_resp.valid === 1'b1) begin
      `CHK("view idx", 13'(vcnt), view_resp.index)
      `CHK("view addr", lst[vcnt[12:0]], view_resp.unit_addr)
      vcnt++;
    end
  end

  task automatic cmd_go(tps_op_t op, logic [12:0] idx, logic [15:0] ua);
    @(posedge core_clk);
    cmd <= '{1'b1, op, idx, ua};
    @(posedge core_clk);
    cmd.valid <= 1'b0;
    r = '0;
    er = 1'b0;
    repeat (3) begin
      #1;
      if (rd_resp.valid === 1'b1) r = rd_resp;
      if (cmd_err === 1'b1) er = 1'b1;
      @(posedge core_clk);
    end
  endtask : cmd_go

  task automatic hop(int gap);
    @(posedge core_clk);
    hop_tick <= 1'b1;
    @(posedge core_clk);
    hop_tick <= 1'b0;
    repeat (gap) @(posedge core_clk);
  endtask : hop

  // Expected polls: one per answering remote, t per silent one, wrap at terminator
  function automatic void plan_polls(int t, int total);
    int k;
    int reps;
    k = 0;
    exp_q.delete();
    exi_q.delete();
    while (exp_q.size() < total) begin
      reps = (lst[k] == 16'h000f || lst[k] == 16'h0015) ? t : 1;
      repeat (reps) begin
        exp_q.push_back(lst[k]);
        exi_q.push_back(13'(k));
      end
      k = (k == 8191 || lst[k + 1] == 16'h0000) ? 0 : k + 1;
    end
    while (exp_q.size() > total) begin
      void'(exp_q.pop_back());
      void'(exi_q.pop_back());
    end
  endfunction : plan_polls

  // One polling run: set timeout, enable standard mode, hop, then stop
  task automatic poll_run(logic [7:0] t, int total);
    tmo <= t;
    plan_polls((t == 8'h00) ? 1 : int'(t), total);
    mode <= MODE_STANDARD;
    repeat (total) hop(6 + $unsigned($random(seed)) % 8);
    `CHK("polls left", 0, exp_q.size())
    mode <= 8'h00;
    repeat (2) @(posedge core_clk);
  endtask : poll_run

  task automatic tally_and_finish();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    reset_n = 1'b0;
    hop_tick = 1'b0;
    mode = 8'h00;
    tmo = 8'h03;
    cmd = '0;
    for (n = 0; n < 8192; n++) lst[n] = 16'(n + 2);
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    n = 0;
    while (list_ready !== 1'b1 && n < 9000) begin
      @(posedge core_clk);
      n++;
    end
    `CHK("ready", 1'b1, list_ready)
    for (n = 0; n < 6; n++) begin
      pa = (n == 5) ? 16'h1fff : 16'($unsigned($random(seed)) % 8192);
      cmd_go(TPS_OP_READ, pa[12:0], 16'h0);
      `CHK("default", lst[pa[12:0]], r.unit_addr)
    end
    $display("defaults done");
    for (n = 0; n < 6; n++) begin
      cmd_go(TPS_OP_WRITE, 13'(n), wr[n]);
      `CHK("accept", 1'b0, er)
      lst[n] = wr[n];
    end
    cmd_go(TPS_OP_WRITE, 13'h2, 16'hffff);
    `CHK("refuse", 1'b1, er)
    for (n = 0; n < 6; n++) begin
      cmd_go(TPS_OP_READ, 13'(n), 16'h0);
      `CHK("readback", lst[n], r.unit_addr)
      `CHK("read valid", 1'b1, r.valid)
      `CHK("read idx", 13'(n), r.index)
    end
    $display("list done");
    repeat (3) hop(6);
    poll_run(8'h03, 12); // clean air timeout
    poll_run(8'h00, 7); // zero acts as one
    poll_run(TIMEOUT_DEFAULT, 25); // default ten hops
    $display("polling done");
    cmd_go(TPS_OP_VIEW, 13'h0, 16'h0);
    n = 0;
    while (vcnt < 8192 && n < 8400) begin
      @(posedge core_clk);
      n++;
    end
    `CHK("view count", 8192, vcnt)
    $display("view done");
    tally_and_finish();
  end
endmodule : testbench
